// ### rtl/sdcag_core.sv
/*
 * Command decoder, address steering and clock-enable gating of a
 * four-bank synchronous DRAM.
 * Assumes all pins are driven by an external controller synchronous to clock.
 */
`timescale 1ns/1ps
`include "sdcag_regs.svh"

module sdcag_core #(
    parameter int BANKS = `SDCAG_BANKS
) (
    input  wire logic               clock,
    input  wire logic               rstn,
    input  wire logic               clkEnable,
    input  wire logic               chipSelectN,
    input  wire logic               rowStrobeN,
    input  wire logic               colStrobeN,
    input  wire logic               writeStrobeN,
    input  wire logic               bankSelectHi,
    input  wire logic               bankSelectLo,
    input  wire sdcag_pkg::sdcag_addr_t multiplexedAddrBus,
    output logic                    cmdValid,
    output sdcag_pkg::sdcag_cmd_e   cmdKind,
    output sdcag_pkg::sdcag_bank_t  cmdBank,
    output sdcag_pkg::sdcag_addr_t  rowAddr,
    output sdcag_pkg::sdcag_col_t   colAddr,
    output logic                    autoPrecharge,
    output logic                    prechargeAll,
    output logic                    modeLoad,
    output sdcag_pkg::sdcag_addr_t  modeOpcode,
    output sdcag_pkg::sdcag_col_t   burstCol,
    output sdcag_pkg::sdcag_pwr_e   powerMode,
    output logic                    receiversOn,
    output logic [BANKS-1:0]        bankActive
);
    import sdcag_pkg::*;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    sdcag_pwr_e  pwr_reg,      pwr_next;
    logic        valid_reg,    valid_next;
    sdcag_cmd_e  kind_reg,     kind_next;
    sdcag_bank_t bank_reg,     bank_next;
    sdcag_addr_t row_reg,      row_next;
    sdcag_col_t  col_reg,      col_next;
    logic        ap_reg,       ap_next;
    logic        all_reg,      all_next;
    logic        mload_reg,    mload_next;
    sdcag_addr_t opcode_reg,   opcode_next;
    sdcag_col_t  burst_reg,    burst_next;
    logic        rxOn_reg,     rxOn_next;

    logic [2:0]  strobes;
    sdcag_bank_t selBank;
    logic        running;
    logic        allIdle;
    sdcag_cmd_e  decoded;
    logic [BANKS-1:0] openReq;
    logic [BANKS-1:0] closeReq;
    logic [BANKS-1:0] activeState;

    sdcag_bank_if bankLink [BANKS] ();

    // ****************************************************************
    // Bank trackers
    // ****************************************************************
    for (genvar b = 0; b < BANKS; b++) begin : g_bank
        assign bankLink[b].openReq  = openReq[b];
        assign bankLink[b].closeReq = closeReq[b];
        assign activeState[b]       = bankLink[b].active;
        sdcag_bank_state u_bank (
            .clock (clock),
            .rstn  (rstn),
            .req   (bankLink[b])
        );
    end

    // ****************************************************************
    // Pin sampling and command decode
    // ****************************************************************
    // Strobes and bank selects taken together at the rising edge
    assign strobes = {rowStrobeN, colStrobeN, writeStrobeN};
    assign selBank = {bankSelectHi, bankSelectLo};
    assign running = (pwr_reg == PWR_RUN);
    assign allIdle = (activeState == '0);

    // Decode only with the internal clock running and chip selected
    always_comb begin
        decoded = CMD_NONE;
        if (running && !chipSelectN) begin
            unique case (strobes)
                `SDCAG_PAT_ROWOPEN: decoded = CMD_ROW_OPEN;
                `SDCAG_PAT_PRECH:   decoded = CMD_PRECHARGE;
                `SDCAG_PAT_WRITE:   decoded = CMD_WRITE;
                `SDCAG_PAT_READ:    decoded = CMD_READ;
                `SDCAG_PAT_MODE:    decoded = CMD_MODE_SET;
                `SDCAG_PAT_REFRESH: decoded = clkEnable ? CMD_REFRESH
                                                        : CMD_SELF_REFRESH;
                `SDCAG_PAT_BSTOP:   decoded = CMD_BURST_STOP;
                `SDCAG_PAT_NOP:     decoded = CMD_NOP;
            endcase
        end
    end

    // Bank open and close requests
    always_comb begin
        openReq  = '0;
        closeReq = '0;
        for (int b = 0; b < BANKS; b++) begin
            if (decoded == CMD_ROW_OPEN && selBank == b[`SDCAG_BANK_W-1:0]) begin
                openReq[b] = 1'b1;
            end
            if (decoded == CMD_PRECHARGE &&
                (multiplexedAddrBus[`SDCAG_AP_BIT] ||
                 selBank == b[`SDCAG_BANK_W-1:0])) begin
                closeReq[b] = 1'b1;
            end
        end
    end

    // ****************************************************************
    // Clock-enable gating
    // ****************************************************************
    // Enter a gated mode when clock-enable is low; exit when it is high
    always_comb begin
        pwr_next  = pwr_reg;
        rxOn_next = rxOn_reg;
        unique case (pwr_reg)
            PWR_RUN: begin
                if (!clkEnable) begin
                    if (decoded == CMD_SELF_REFRESH && allIdle) begin
                        pwr_next = PWR_SELF_REFRESH;
                    end else if (allIdle) begin
                        pwr_next = PWR_DOWN;
                    end else begin
                        pwr_next = PWR_SUSPEND;
                    end
                end
            end
            PWR_SUSPEND: begin
                if (clkEnable) begin
                    pwr_next = PWR_RUN;
                end
            end
            PWR_DOWN, PWR_SELF_REFRESH: begin
                // Only clock-enable is sensed here; no setup to the pipeline
                if (clkEnable) begin
                    pwr_next = PWR_RUN;
                end
            end
        endcase
        // Receivers off in either low-power mode
        rxOn_next = (pwr_next != PWR_DOWN) &&
                    (pwr_next != PWR_SELF_REFRESH);
    end

    // ****************************************************************
    // Address steering and burst address
    // ****************************************************************
    always_comb begin
        valid_next  = (decoded != CMD_NONE);
        kind_next   = decoded;
        bank_next   = bank_reg;
        row_next    = row_reg;
        col_next    = col_reg;
        ap_next     = ap_reg;
        all_next    = all_reg;
        mload_next  = 1'b0;
        opcode_next = opcode_reg;
        burst_next  = burst_reg;
        if (running) begin
            burst_next = burst_reg + `SDCAG_COL_STEP;
        end
        unique case (decoded)
            CMD_ROW_OPEN: begin
                bank_next = selBank;
                row_next  = multiplexedAddrBus;
            end
            CMD_WRITE, CMD_READ: begin
                bank_next  = selBank;
                col_next   = multiplexedAddrBus[`SDCAG_COL_W-1:0];
                ap_next    = multiplexedAddrBus[`SDCAG_AP_BIT];
                burst_next = multiplexedAddrBus[`SDCAG_COL_W-1:0];
            end
            CMD_PRECHARGE: begin
                bank_next = selBank;
                all_next  = multiplexedAddrBus[`SDCAG_AP_BIT];
            end
            CMD_MODE_SET: begin
                mload_next  = 1'b1;
                opcode_next = multiplexedAddrBus;
            end
            default: begin
            end
        endcase
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clock) begin
        if (!rstn) begin
            pwr_reg    <= PWR_RUN;
            rxOn_reg   <= 1'b1;
            valid_reg  <= 1'b0;
            kind_reg   <= CMD_NONE;
            bank_reg   <= `SDCAG_RST_BANK;
            row_reg    <= `SDCAG_RST_ADDR;
            col_reg    <= `SDCAG_RST_COL;
            ap_reg     <= 1'b0;
            all_reg    <= 1'b0;
            mload_reg  <= 1'b0;
            opcode_reg <= `SDCAG_RST_ADDR;
            burst_reg  <= `SDCAG_RST_COL;
        end else begin
            pwr_reg    <= pwr_next;
            rxOn_reg   <= rxOn_next;
            valid_reg  <= valid_next;
            kind_reg   <= kind_next;
            bank_reg   <= bank_next;
            row_reg    <= row_next;
            col_reg    <= col_next;
            ap_reg     <= ap_next;
            all_reg    <= all_next;
            mload_reg  <= mload_next;
            opcode_reg <= opcode_next;
            burst_reg  <= burst_next;
        end
    end

    // Outputs straight from flops
    assign cmdValid      = valid_reg;
    assign cmdKind       = kind_reg;
    assign cmdBank       = bank_reg;
    assign rowAddr       = row_reg;
    assign colAddr       = col_reg;
    assign autoPrecharge = ap_reg;
    assign prechargeAll  = all_reg;
    assign modeLoad      = mload_reg;
    assign modeOpcode    = opcode_reg;
    assign burstCol      = burst_reg;
    assign powerMode     = pwr_reg;
    assign receiversOn   = rxOn_reg;
    assign bankActive    = activeState;

endmodule : sdcag_core

// ### rtl/sdcag_regs.svh
/*
 * Constants of the SDRAM command, address and clock-gating block.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef SDCAG_REGS_SVH
`define SDCAG_REGS_SVH

// Geometry
`define SDCAG_BANKS       4
`define SDCAG_BANK_W      2
`define SDCAG_ADDR_W      13
`define SDCAG_COL_W       9
`define SDCAG_AP_BIT      10

// Strobe patterns {row, column, write}, active low
`define SDCAG_PAT_MODE    3'h0
`define SDCAG_PAT_REFRESH 3'h1
`define SDCAG_PAT_PRECH   3'h2
`define SDCAG_PAT_ROWOPEN 3'h3
`define SDCAG_PAT_WRITE   3'h4
`define SDCAG_PAT_READ    3'h5
`define SDCAG_PAT_BSTOP   3'h6
`define SDCAG_PAT_NOP     3'h7

// Reset values and burst column step
`define SDCAG_RST_BANK    2'h0
`define SDCAG_RST_ADDR    13'h0000
`define SDCAG_RST_COL     9'h000
`define SDCAG_COL_STEP    9'h001

`endif

// ### rtl/sdcag_pkg.sv
/*
 * Types shared by the command, address and clock-gating logic.
 * Assumes the constants header is on the include path.
 */
`include "sdcag_regs.svh"

package sdcag_pkg;

    // Decoded command
    typedef enum logic [3:0] {
        CMD_NONE,
        CMD_ROW_OPEN,
        CMD_PRECHARGE,
        CMD_WRITE,
        CMD_READ,
        CMD_MODE_SET,
        CMD_REFRESH,
        CMD_SELF_REFRESH,
        CMD_BURST_STOP,
        CMD_NOP
    } sdcag_cmd_e;

    // Clock-gating mode
    typedef enum logic [1:0] {
        PWR_RUN,
        PWR_SUSPEND,
        PWR_DOWN,
        PWR_SELF_REFRESH
    } sdcag_pwr_e;

    typedef logic [`SDCAG_BANK_W-1:0] sdcag_bank_t;
    typedef logic [`SDCAG_ADDR_W-1:0] sdcag_addr_t;
    typedef logic [`SDCAG_COL_W-1:0]  sdcag_col_t;

endpackage : sdcag_pkg

// ### rtl/sdcag_bank_if.sv
/*
 * Open and close requests to one bank tracker, and its state back.
 * Assumes one instance per bank, driven by the core decoder.
 */
`timescale 1ns/1ps

interface sdcag_bank_if;
    logic openReq;
    logic closeReq;
    logic active;

    modport ctrl (output openReq, output closeReq, input active);
    modport bank (input openReq, input closeReq, output active);
endinterface : sdcag_bank_if

// ### rtl/sdcag_bank_state.sv
/*
 * Idle or active state of one bank.
 * Assumes requests are one-cycle pulses from the core decoder.
 */
`timescale 1ns/1ps

module sdcag_bank_state (
    input wire logic    clock,
    input wire logic    rstn,
    sdcag_bank_if.bank  req
);
    import sdcag_pkg::*;

    logic active_reg;
    logic active_next;

    // Close wins over open only when both come at once
    always_comb begin
        active_next = active_reg;
        if (req.openReq) begin
            active_next = 1'b1;
        end
        if (req.closeReq) begin
            active_next = 1'b0;
        end
    end

    // State register
    always_ff @(posedge clock) begin
        if (!rstn) begin
            active_reg <= 1'b0;
        end else begin
            active_reg <= active_next;
        end
    end

    assign req.active = active_reg;

endmodule : sdcag_bank_state

// ### bench/sdcag_core_properties.sv
/* Concurrent checks on the ports of the command, address and clock-gating core.
   Assumes it is bound to sdcag_core and sees only that module's ports. */
`timescale 1ns/1ps

module sdcag_core_properties #(
    parameter int BANKS = 4
) (
    input wire logic                   clock,
    input wire logic                   rstn,
    input wire logic                   clkEnable,
    input wire logic                   chipSelectN,
    input wire logic                   rowStrobeN,
    input wire logic                   colStrobeN,
    input wire logic                   writeStrobeN,
    input wire logic                   bankSelectHi,
    input wire logic                   bankSelectLo,
    input wire sdcag_pkg::sdcag_addr_t multiplexedAddrBus,
    input wire logic                   cmdValid,
    input wire sdcag_pkg::sdcag_cmd_e  cmdKind,
    input wire sdcag_pkg::sdcag_bank_t cmdBank,
    input wire sdcag_pkg::sdcag_addr_t rowAddr,
    input wire sdcag_pkg::sdcag_col_t  colAddr,
    input wire logic                   autoPrecharge,
    input wire logic                   prechargeAll,
    input wire logic                   modeLoad,
    input wire sdcag_pkg::sdcag_addr_t modeOpcode,
    input wire sdcag_pkg::sdcag_col_t  burstCol,
    input wire sdcag_pkg::sdcag_pwr_e  powerMode,
    input wire logic                   receiversOn,
    input wire logic [BANKS-1:0]       bankActive
);
    import sdcag_pkg::*;

    // Strobe pattern, running flag and selected bank
    wire [2:0] pat  = {rowStrobeN, colStrobeN, writeStrobeN};
    wire       run  = powerMode == PWR_RUN;
    wire       go   = run && !chipSelectN;
    wire [1:0] bank = {bankSelectHi, bankSelectLo};

    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);

    AST_ROW_OPEN : assert property (
        go && pat == 3'h3 |=> cmdValid && cmdKind == CMD_ROW_OPEN
        && rowAddr == $past(multiplexedAddrBus) && cmdBank == $past(bank)
        && bankActive[$past(bank)]) else $error("row open not reflected");
    AST_PRECHARGE : assert property (
        go && pat == 3'h2 |=> cmdKind == CMD_PRECHARGE
        && prechargeAll == $past(multiplexedAddrBus[10])
        && ($past(multiplexedAddrBus[10]) ? bankActive == '0 : !bankActive[$past(bank)]))
        else $error("precharge not reflected");
    AST_COLUMN : assert property (
        go && pat[2:1] == 2'b10 |=> cmdKind == ($past(writeStrobeN) ? CMD_READ : CMD_WRITE)
        && colAddr == $past(multiplexedAddrBus[8:0]) && burstCol == colAddr
        && autoPrecharge == $past(multiplexedAddrBus[10])) else $error("column access wrong");
    AST_MODE_SET : assert property (
        go && pat == 3'h0 |=> modeLoad && modeOpcode == $past(multiplexedAddrBus))
        else $error("mode op-code not loaded");
    AST_DESELECT : assert property (
        chipSelectN || !run |=> !cmdValid && !modeLoad) else $error("masked command decoded");
    AST_BURST_FREEZE : assert property (
        !run |=> $stable(burstCol)) else $error("burst column moved while gated");
    AST_GATE_ENTRY : assert property (
        run && !clkEnable && chipSelectN
        |=> powerMode == ($past(bankActive) == '0 ? PWR_DOWN : PWR_SUSPEND))
        else $error("wrong gated mode entered");
    AST_SELF_REFRESH : assert property (
        go && pat == 3'h1 && !clkEnable && bankActive == '0
        |=> powerMode == PWR_SELF_REFRESH && cmdKind == CMD_SELF_REFRESH)
        else $error("self refresh not entered");
    AST_GATE_EXIT : assert property (
        !run |=> powerMode == ($past(clkEnable) ? PWR_RUN : $past(powerMode)))
        else $error("clock enable not sensed in gated mode");
    AST_RECEIVERS : assert property (
        receiversOn != powerMode[1]) else $error("receivers wrong for mode");
endmodule : sdcag_core_properties

bind sdcag_core sdcag_core_properties #(.BANKS(BANKS)) i_props (.*);

// ### bench/sdcag_ctrl_model.sv
/* Memory controller model that drives every command pin of the core.
   Assumes the bench calls issue and keeps the bank-state ordering itself. */
`timescale 1ns/1ps

module sdcag_ctrl_model (
    input  wire logic             clock,
    output logic                  clkEnable,
    output logic                  chipSelectN,
    output logic                  rowStrobeN,
    output logic                  colStrobeN,
    output logic                  writeStrobeN,
    output logic                  bankSelectHi,
    output logic                  bankSelectLo,
    output sdcag_pkg::sdcag_addr_t multiplexedAddrBus
);
    import sdcag_pkg::*;

    // Pins idle and deselected from time zero
    initial begin
        clkEnable = 1'b1;
        chipSelectN = 1'b1;
        {rowStrobeN, colStrobeN, writeStrobeN} = 3'h7;
        {bankSelectHi, bankSelectLo} = 2'h0;
        multiplexedAddrBus = 13'h0000;
    end

    // Presents one command for the next rising edge, changed at the falling edge
    task automatic issue(input logic csN, input logic [2:0] pat, input logic [1:0] bank,
                         input sdcag_addr_t addr, input logic cke);
        @(negedge clock);
        chipSelectN = csN;
        {rowStrobeN, colStrobeN, writeStrobeN} = pat;
        {bankSelectHi, bankSelectLo} = bank;
        multiplexedAddrBus = addr;
        clkEnable = cke;
    endtask : issue
endmodule : sdcag_ctrl_model

// ### bench/tb.sv
/* Self-checking bench of the command, address and clock-gating core.
   Assumes the controller model drives all command pins. */
`timescale 1ns/1ps

module tb;
    import sdcag_pkg::*;

    logic clock, rstn, clkEnable, chipSelectN, rowStrobeN, colStrobeN, writeStrobeN;
    logic bankSelectHi, bankSelectLo, cmdValid, autoPrecharge, prechargeAll, modeLoad;
    logic receiversOn;
    sdcag_addr_t multiplexedAddrBus, rowAddr, modeOpcode;
    sdcag_cmd_e  cmdKind;
    sdcag_bank_t cmdBank;
    sdcag_col_t  colAddr, burstCol;
    sdcag_pwr_e  powerMode;
    logic [3:0]  bankActive;
    int          nMismatch, compares, cycles;

    sdcag_ctrl_model ctrl (.clock, .clkEnable, .chipSelectN, .rowStrobeN, .colStrobeN,
        .writeStrobeN, .bankSelectHi, .bankSelectLo, .multiplexedAddrBus);
    sdcag_core i_sdcag_core (.clock, .rstn, .clkEnable, .chipSelectN, .rowStrobeN,
        .colStrobeN, .writeStrobeN, .bankSelectHi, .bankSelectLo, .multiplexedAddrBus,
        .cmdValid, .cmdKind, .cmdBank, .rowAddr, .colAddr, .autoPrecharge, .prechargeAll,
        .modeLoad, .modeOpcode, .burstCol, .powerMode, .receiversOn, .bankActive);

    // Clock of 4 ns
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic finish_test();
        if (nMismatch == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            nMismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Deselected cycle with the address lines scrambled
    task automatic nop(input logic cke);
        ctrl.issue(1'b1, 3'h7, 2'h0, ~multiplexedAddrBus, cke);
    endtask : nop

    task automatic t_open_all();
        for (int b = 0; b < 4; b++) begin
            ctrl.issue(1'b0, 3'h3, b[1:0], 13'h1800 | 13'(b), 1'b1);
            nop(1'b1);
            chk(cmdValid, 1'b1);
            chk(cmdBank, b[1:0]);
            chk(rowAddr, 13'h1800 | 13'(b));
            chk(bankActive[b], 1'b1);
        end
    endtask : t_open_all

    task automatic t_deselect();
        ctrl.issue(1'b1, 3'h2, 2'h0, 13'h0400, 1'b1);
        nop(1'b1);
        chk(cmdValid, 1'b0);
        chk(bankActive, 4'hF);
    endtask : t_deselect

    task automatic t_column();
        for (int i = 0; i < 4; i++) begin
            ctrl.issue(1'b0, i[0] ? 3'h5 : 3'h4, 2'h1, {2'h3, i[1], 1'b1, 9'h1A5 + 9'(i)}, 1'b1);
            nop(1'b1);
            chk(cmdKind, i[0] ? CMD_READ : CMD_WRITE);
            chk(colAddr, 9'h1A5 + 9'(i));
            chk(autoPrecharge, i[1]);
        end
    endtask : t_column

    task automatic t_suspend();
        ctrl.issue(1'b0, 3'h5, 2'h2, 13'h0010, 1'b1);
        nop(1'b1);
        nop(1'b0);
        nop(1'b0);
        nop(1'b0);
        chk(powerMode, PWR_SUSPEND);
        chk(burstCol, 9'h012);
        ctrl.issue(1'b0, 3'h0, 2'h0, 13'h0ABC, 1'b1);
        nop(1'b1);
        chk(modeLoad, 1'b0);
        chk(powerMode, PWR_RUN);
        chk(burstCol, 9'h012);
    endtask : t_suspend

    task automatic t_precharge();
        ctrl.issue(1'b0, 3'h2, 2'h2, 13'h1BFF, 1'b1);
        nop(1'b1);
        chk(cmdKind, CMD_PRECHARGE);
        chk(prechargeAll, 1'b0);
        chk(bankActive, 4'hB);
        ctrl.issue(1'b0, 3'h2, 2'h0, 13'h0400, 1'b1);
        nop(1'b1);
        chk(prechargeAll, 1'b1);
        chk(bankActive, 4'h0);
    endtask : t_precharge

    task automatic t_mode();
        ctrl.issue(1'b0, 3'h0, 2'h3, 13'h0A5A, 1'b1);
        nop(1'b1);
        chk(modeLoad, 1'b1);
        chk(modeOpcode, 13'h0A5A);
        ctrl.issue(1'b0, 3'h6, 2'h0, 13'h0000, 1'b1);
        ctrl.issue(1'b0, 3'h7, 2'h0, 13'h0000, 1'b1);
        chk(cmdKind, CMD_BURST_STOP);
        nop(1'b1);
        chk(cmdKind, CMD_NOP);
        chk(cmdValid, 1'b1);
    endtask : t_mode

    task automatic t_power();
        nop(1'b0);
        nop(1'b0);
        chk(powerMode, PWR_DOWN);
        chk(receiversOn, 1'b0);
        nop(1'b1);
        nop(1'b1);
        chk(receiversOn, 1'b1);
        ctrl.issue(1'b0, 3'h1, 2'h0, 13'h0000, 1'b0);
        nop(1'b0);
        chk(powerMode, PWR_SELF_REFRESH);
        chk(cmdKind, CMD_SELF_REFRESH);
        chk(receiversOn, 1'b0);
        ctrl.issue(1'b0, 3'h1, 2'h0, 13'h0000, 1'b1);
        nop(1'b1);
        chk(powerMode, PWR_RUN);
        chk(cmdValid, 1'b0);
        ctrl.issue(1'b0, 3'h1, 2'h0, 13'h0000, 1'b1);
        nop(1'b1);
        chk(cmdKind, CMD_REFRESH);
    endtask : t_power

    // Cuts a hang short
    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            nMismatch++;
            finish_test();
        end
    end

    // Reset, then the scenarios in bank-state order
    initial begin
        rstn = 1'b0;
        repeat (5) @(posedge clock);
        @(negedge clock) rstn = 1'b1;
        t_open_all();
        t_deselect();
        t_column();
        t_suspend();
        t_precharge();
        t_mode();
        t_power();
        finish_test();
    end
endmodule : tb
